// file: spc_defines.svh
// Purpose: offsets, field positions and reset values of the serial control
// Assumes: byte-wide register port, 3-bit register index
// Notes: included by the control block only; its serial clock pin driver uses none of it
//
// Function
// - the transmit-empty request is raised only while tx_irq_en (bit 7) is 1.
// - receive-full and receive-error requests are raised only while rx_irq_en (bit 6) is 1.
// - transmission runs only while tx_on (bit 5) is 1.
// - reception runs only while rx_on (bit 4) is 1.
// - addr_filter_en (bit 3) acts only in asynchronous multiprocessor mode.
// - an active filter drops characters with multiprocessor bit 0 and sets no receive flags.
// - a character with multiprocessor bit 1 clears addr_filter_en and is received normally.
// - the transmit-done request is raised only while tx_done_irq_en (bit 2) is 1.
// - asynchronous code 00 uses the internal baud generator and leaves the clock pin idle.
// - asynchronous code 01 uses the internal generator and drives a bit-rate clock on the pin.
// - asynchronous code 10 takes a 16x bit-rate clock from the pin; code 11 is reserved.
// - synchronous code 00 uses the internal clock and drives it on the pin.
// - synchronous code 10 takes the transfer clock from the remote party; 01 and 11 reserved.
// - the mode selector picks asynchronous when 0 and clocked synchronous when 1.
// - tx_empty_flag reads as set whenever tx_on is 0.
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// register indices
`define SPC_OFF_CTRL 3'h0
`define SPC_OFF_MODE 3'h1
`define SPC_OFF_STATUS 3'h2
`define SPC_OFF_MASK 3'h3
`define SPC_OFF_DATA 3'h4

// control register fields
`define SPC_CTRL_TX_IRQ_EN 7
`define SPC_CTRL_RX_IRQ_EN 6
`define SPC_CTRL_TX_ON 5
`define SPC_CTRL_RX_ON 4
`define SPC_CTRL_ADDR_FILTER_EN 3
`define SPC_CTRL_TX_DONE_IRQ_EN 2
`define SPC_CTRL_CLK_SRC_HI 1
`define SPC_CTRL_CLK_SRC_LO 0

// mode register fields
`define SPC_MODE_COMM_SYNC 7
`define SPC_MODE_MULTIPROC 2

// status register fields
`define SPC_ST_TX_EMPTY 7
`define SPC_ST_RX_FULL 6
`define SPC_ST_OVERRUN 5
`define SPC_ST_FRAME_ERR 4
`define SPC_ST_PARITY_ERR 3
`define SPC_ST_TX_DONE 2
`define SPC_ST_MPB_RX 1

// reset values
`define SPC_RST_CTRL 8'h00
`define SPC_RST_MODE 8'h00
`define SPC_RST_STATUS 8'h84
`define SPC_RST_MASK 8'h00
`define SPC_RST_DATA 8'hff

// sticky bits that software clears by writing one
`define SPC_ST_W1C_MASK 8'hfc

`endif

// file: spc_pkg.sv
// Purpose: types shared by the serial control and its clock pin driver
// Assumes: nothing beyond the defines header
// Notes: clock source decode lives here beside the mode type; only the control block calls it, the pin driver uses just the type
`default_nettype none

package spc_pkg;

	// resolved use of the serial clock pin
	typedef enum logic [2:0] {
		SPC_CLK_NONE = 3'b000,
		SPC_CLK_ASYNC_INT = 3'b001,
		SPC_CLK_ASYNC_INT_OUT = 3'b010,
		SPC_CLK_ASYNC_EXT16 = 3'b011,
		SPC_CLK_SYNC_INT_OUT = 3'b100,
		SPC_CLK_SYNC_EXT = 3'b101
	} spc_clk_mode_t;

	// mode bit and two-bit code to pin usage; reserved codes give none
	function automatic spc_clk_mode_t spc_clk_decode(input logic sync,
		input logic [1:0] code);
		spc_clk_mode_t m;
		m = SPC_CLK_NONE;
		if (!sync) begin
			case (code)
				2'h0: m = SPC_CLK_ASYNC_INT;
				2'h1: m = SPC_CLK_ASYNC_INT_OUT;
				2'h2: m = SPC_CLK_ASYNC_EXT16;
				default: m = SPC_CLK_NONE;
			endcase
		end else begin
			case (code)
				2'h0: m = SPC_CLK_SYNC_INT_OUT;
				2'h2: m = SPC_CLK_SYNC_EXT;
				default: m = SPC_CLK_NONE;
			endcase
		end
		return m;
	endfunction

endpackage

`default_nettype wire

// file: spc_sck_if.sv
// Purpose: bundle between the control block and the clock pin driver
// Assumes: one clock domain
// Notes: the pin itself stays as three plain signals on the top module
`default_nettype none

interface spc_sck_if;
	import spc_pkg::*;
	spc_clk_mode_t mode;
	logic half_tick;
	logic pin_i;
	logic pin_o;
	logic pin_oe_n;
	logic ext_edge;

	modport ctrl (output mode, output half_tick, output pin_i,
		input pin_o, input pin_oe_n, input ext_edge);
	modport drv (input mode, input half_tick, input pin_i,
		output pin_o, output pin_oe_n, output ext_edge);
endinterface

`default_nettype wire

// file: spc_sck_drv.sv
// Purpose: drives or samples the serial clock pin per clock source
// Assumes: pin input synchronous to mclk; half_tick is one pulse per half bit
// Notes: driven clock idles high between uses
`default_nettype none

module spc_sck_drv
	import spc_pkg::*;
(
	input wire logic mclk, // system clock
	input wire logic rstn, // synchronous reset, low active
	spc_sck_if.drv sck // pin control bundle
);

	logic pin_prev;
	logic drive;

	assign drive = (sck.mode == SPC_CLK_ASYNC_INT_OUT) ||
		(sck.mode == SPC_CLK_SYNC_INT_OUT);

	// clock output, toggled each half bit so one period is one bit
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			sck.pin_o <= 1'b1;
		end else if (!drive) begin
			sck.pin_o <= 1'b1;
		end else if (sck.half_tick) begin
			sck.pin_o <= ~sck.pin_o;
		end
	end

	// enable low only in the two driving codes
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			sck.pin_oe_n <= 1'b1;
		end else begin
			sck.pin_oe_n <= ~drive;
		end
	end

	// rising edge of an external clock on the pin
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			pin_prev <= 1'b1;
			sck.ext_edge <= 1'b0;
		end else begin
			pin_prev <= sck.pin_i;
			sck.ext_edge <= sck.pin_i && !pin_prev &&
				((sck.mode == SPC_CLK_ASYNC_EXT16) ||
				(sck.mode == SPC_CLK_SYNC_EXT));
		end
	end

endmodule // spc_sck_drv

`default_nettype wire

// file: spc_ctrl.sv
// Purpose: control register, status flags and requests of a serial unit
// Assumes: shift logic and baud generator sit outside and report events
// Notes: read data appear the cycle after the read strobe
//
// The register offsets and the address-and-strobe port were decided locally.
`include "spc_defines.svh"
`default_nettype none

module spc_ctrl
	import spc_pkg::*;
#(
	parameter int ADDR_W = 3 // register index width
)
(
	input wire logic mclk, // system clock, 100 MHz
	input wire logic rstn, // synchronous reset, low active
	input wire logic [ADDR_W-1:0] reg_addr, // register index
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after strobe
	input wire logic tx_shift_load, // data moved into shift register
	input wire logic tx_last_bit, // last bit of a character sent
	input wire logic rx_char_done, // a character was received
	input wire logic rx_mpb, // its multiprocessor bit
	input wire logic rx_frame_err, // framing error on it
	input wire logic rx_parity_err, // parity error on it
	input wire logic rx_overrun, // overrun on it
	input wire logic half_bit_tick, // baud generator half-bit pulse
	input wire logic serial_clk_pin_i, // serial clock pin level
	output logic serial_clk_pin_o, // serial clock pin drive
	output logic serial_clk_pin_oe_n, // pin enable, low drives
	output logic tx_run, // transmitter may run
	output logic rx_run, // receiver may run
	output logic rx_accept, // pulse: store received character
	output logic [7:0] tx_data, // transmit data
	output logic tx_data_wr, // pulse: new transmit data
	output logic brg_internal, // internal baud generator in use
	output logic ext_clk_16x, // pin clock is 16x bit rate
	output logic ext_clk_edge, // pulse: rising edge on pin clock
	output logic tx_empty_irq, // transmit-empty request
	output logic rx_full_irq, // receive-full request
	output logic rx_err_irq, // receive-error request
	output logic tx_done_irq, // transmit-done request
	output logic irq // summary interrupt, level
);

	// refuse index widths that cannot hold the map, at elaboration
	if (ADDR_W < 3) begin : g_addr_w_chk
		$error("spc_ctrl: ADDR_W must be at least 3");
	end

	logic [7:0] ctrl_reg;
	logic [7:0] mode_reg;
	logic [7:0] status_reg;
	logic [7:0] mask_reg;
	logic [7:0] next_status;
	logic [7:0] clr_bits;
	logic [7:0] set_bits;
	logic [2:0] idx;
	logic hit;
	logic wr_ctrl;
	logic wr_mode;
	logic wr_status;
	logic wr_mask;
	logic wr_data;
	logic comm_sync;
	logic multiproc_mode;
	logic tx_on;
	logic rx_on;
	logic addr_filter_en;
	logic filter_live;
	logic rx_event;
	logic rx_drop;
	logic rx_wake;
	logic rx_keep;
	logic tx_empty_flag;
	logic rx_full_flag;
	logic frame_err_flag;
	logic overrun_flag;
	logic parity_err_flag;
	logic tx_done_flag;
	logic rx_err_any;
	logic rx_clean;
	logic tx_load_ev;
	logic tx_end_ev;
	logic brg_sel;
	logic ext16_sel;
	logic [1:0] clk_code;
	logic [7:0] irq_src;
	spc_clk_mode_t clk_mode;

	spc_sck_if sck_bus();

	// sticky flag update, set beats clear
	function automatic logic [7:0] spc_sticky(input logic [7:0] cur,
		input logic [7:0] set, input logic [7:0] clr);
		return (cur & ~clr) | set;
	endfunction

	// strobe aimed at one register index
	function automatic logic spc_sel(input logic strobe,
		input logic [2:0] at, input logic [2:0] off);
		return strobe && (at == off);
	endfunction

	// address decode; upper index bits must be zero to hit
	assign idx = reg_addr[2:0];
	assign hit = (ADDR_W == 3) ? 1'b1 : (reg_addr >> 3) == '0;
	assign wr_ctrl = spc_sel(reg_wr && hit, idx, `SPC_OFF_CTRL);
	assign wr_mode = spc_sel(reg_wr && hit, idx, `SPC_OFF_MODE);
	assign wr_status = spc_sel(reg_wr && hit, idx, `SPC_OFF_STATUS);
	assign wr_mask = spc_sel(reg_wr && hit, idx, `SPC_OFF_MASK);
	assign wr_data = spc_sel(reg_wr && hit, idx, `SPC_OFF_DATA);

	// control and mode field views
	assign tx_on = ctrl_reg[`SPC_CTRL_TX_ON];
	assign rx_on = ctrl_reg[`SPC_CTRL_RX_ON];
	assign addr_filter_en = ctrl_reg[`SPC_CTRL_ADDR_FILTER_EN];
	assign comm_sync = mode_reg[`SPC_MODE_COMM_SYNC];
	assign multiproc_mode = mode_reg[`SPC_MODE_MULTIPROC];

	// status field views
	assign tx_empty_flag = status_reg[`SPC_ST_TX_EMPTY];
	assign rx_full_flag = status_reg[`SPC_ST_RX_FULL];
	assign overrun_flag = status_reg[`SPC_ST_OVERRUN];
	assign frame_err_flag = status_reg[`SPC_ST_FRAME_ERR];
	assign parity_err_flag = status_reg[`SPC_ST_PARITY_ERR];
	assign tx_done_flag = status_reg[`SPC_ST_TX_DONE];

	// filter only counts in asynchronous multiprocessor mode
	assign filter_live = addr_filter_en && multiproc_mode &&
		!comm_sync;

	// receive event sorting
	assign rx_event = rx_char_done && rx_on;
	assign rx_drop = rx_event && filter_live && !rx_mpb;
	assign rx_wake = rx_event && filter_live && rx_mpb;
	assign rx_keep = rx_event && !rx_drop;
	assign rx_clean = rx_keep && !rx_frame_err && !rx_parity_err &&
		!rx_overrun;

	// any receive error flag standing
	assign rx_err_any = frame_err_flag || overrun_flag || parity_err_flag;

	// transmit events only count while the transmitter is on
	assign tx_load_ev = tx_shift_load && tx_on;
	assign tx_end_ev = tx_last_bit && tx_on && tx_empty_flag;

	// control register; hardware filter clear wins over a write
	// so a stale software write cannot re-arm a filter just released
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ctrl_reg <= `SPC_RST_CTRL;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= reg_wdata;
			end
			if (rx_wake) begin
				ctrl_reg[`SPC_CTRL_ADDR_FILTER_EN] <= 1'b0;
			end
		end
	end

	// mode register
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			mode_reg <= `SPC_RST_MODE;
		end else if (wr_mode) begin
			mode_reg <= reg_wdata;
		end
	end

	// interrupt mask register
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			mask_reg <= `SPC_RST_MASK;
		end else if (wr_mask) begin
			mask_reg <= reg_wdata;
		end
	end

	// hardware set terms for the sticky flags
	always_comb begin
		set_bits = 8'h00;
		set_bits[`SPC_ST_TX_EMPTY] = !tx_on || tx_load_ev;
		set_bits[`SPC_ST_TX_DONE] = !tx_on || tx_end_ev;
		set_bits[`SPC_ST_RX_FULL] = rx_clean;
		set_bits[`SPC_ST_FRAME_ERR] = rx_keep && rx_frame_err;
		set_bits[`SPC_ST_OVERRUN] = rx_keep && rx_overrun;
		set_bits[`SPC_ST_PARITY_ERR] = rx_keep && rx_parity_err;
	end

	// software clear terms: write one, or new transmit data
	always_comb begin
		clr_bits = 8'h00;
		if (wr_status) begin
			clr_bits = reg_wdata & `SPC_ST_W1C_MASK;
		end
		if (wr_data) begin
			clr_bits[`SPC_ST_TX_EMPTY] = 1'b1;
			clr_bits[`SPC_ST_TX_DONE] = 1'b1;
		end
	end

	// next status; received multiprocessor bit kept while rx is off
	always_comb begin
		next_status = spc_sticky(status_reg, set_bits, clr_bits);
		next_status[`SPC_ST_MPB_RX] = rx_keep ? rx_mpb :
			status_reg[`SPC_ST_MPB_RX];
		next_status[0] = 1'b0;
	end

	// status register
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			status_reg <= `SPC_RST_STATUS;
		end else begin
			status_reg <= next_status;
		end
	end

	// transmit data register and its load pulse
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			tx_data <= `SPC_RST_DATA;
			tx_data_wr <= 1'b0;
		end else begin
			tx_data_wr <= wr_data && tx_on;
			if (wr_data) begin
				tx_data <= reg_wdata;
			end
		end
	end

	// read data, valid only the cycle after the strobe
	// zero otherwise so an or-ed read bus of several slaves stays clean
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd && hit) begin
			case (idx)
				`SPC_OFF_CTRL: reg_rdata <= ctrl_reg;
				`SPC_OFF_MODE: reg_rdata <= mode_reg;
				`SPC_OFF_STATUS: reg_rdata <= status_reg;
				`SPC_OFF_MASK: reg_rdata <= mask_reg;
				`SPC_OFF_DATA: reg_rdata <= tx_data;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// transfer enables toward the shift logic
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			tx_run <= 1'b0;
			rx_run <= 1'b0;
		end else begin
			tx_run <= tx_on;
			rx_run <= rx_on;
		end
	end

	// accepted characters reach the receive buffer
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rx_accept <= 1'b0;
		end else begin
			rx_accept <= rx_keep;
		end
	end

	// clock source decode from mode and code bits
	assign clk_code = {ctrl_reg[`SPC_CTRL_CLK_SRC_HI],
		ctrl_reg[`SPC_CTRL_CLK_SRC_LO]};
	assign clk_mode = spc_clk_decode(comm_sync, clk_code);

	// sources fed by the internal generator or by a 16x pin clock
	assign brg_sel = (clk_mode == SPC_CLK_ASYNC_INT) ||
		(clk_mode == SPC_CLK_ASYNC_INT_OUT) ||
		(clk_mode == SPC_CLK_SYNC_INT_OUT);
	assign ext16_sel = (clk_mode == SPC_CLK_ASYNC_EXT16);

	// baud generator and external clock selection, registered
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			brg_internal <= 1'b0;
			ext_clk_16x <= 1'b0;
		end else begin
			brg_internal <= brg_sel;
			ext_clk_16x <= ext16_sel;
		end
	end

	// hand the decoded source to the pin driver
	assign sck_bus.mode = clk_mode;
	assign sck_bus.half_tick = half_bit_tick;
	assign sck_bus.pin_i = serial_clk_pin_i;

	spc_sck_drv u_sck (
		.mclk(mclk),
		.rstn(rstn),
		.sck(sck_bus.drv)
	);

	assign serial_clk_pin_o = sck_bus.pin_o;
	assign serial_clk_pin_oe_n = sck_bus.pin_oe_n;
	assign ext_clk_edge = sck_bus.ext_edge;

	// per-source requests: enable and condition, every cycle
	// registered, so a request trails its flag by one cycle
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			tx_empty_irq <= 1'b0;
			rx_full_irq <= 1'b0;
			rx_err_irq <= 1'b0;
			tx_done_irq <= 1'b0;
		end else begin
			tx_empty_irq <= ctrl_reg[`SPC_CTRL_TX_IRQ_EN] &&
				tx_empty_flag;
			rx_full_irq <= ctrl_reg[`SPC_CTRL_RX_IRQ_EN] &&
				rx_full_flag;
			rx_err_irq <= ctrl_reg[`SPC_CTRL_RX_IRQ_EN] &&
				rx_err_any;
			tx_done_irq <= ctrl_reg[`SPC_CTRL_TX_DONE_IRQ_EN] &&
				tx_done_flag;
		end
	end

	// masked sticky bits; the read-only multiprocessor bit never counts
	assign irq_src = status_reg & mask_reg & `SPC_ST_W1C_MASK;

	// summary interrupt, high while any unmasked sticky bit stands
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |irq_src;
		end
	end

endmodule // spc_ctrl

`default_nettype wire

// file: spc_remote.sv
// Purpose: remote serial station on the serial clock pin
// Assumes: bench raises clk_run when the remote must supply the clock
// Notes: a released pin rests high on its pull-up
`default_nettype none

module spc_remote (
	input wire logic mclk, // system clock
	input wire logic rstn, // reset, low active
	input wire logic clk_run, // supply a transfer clock
	input wire logic pin_o, // device pin drive
	input wire logic pin_oe_n, // device drives when low
	output logic pin_i // resolved pin level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div;
	logic rclk;

	// remote clock, half period three cycles, stands high when unused
	always_ff @(posedge mclk) begin
		if (!rstn || !clk_run) begin
			div <= 2'h0;
			rclk <= 1'b1;
		end else if (div == 2'h2) begin
			div <= 2'h0;
			rclk <= ~rclk;
		end else begin
			div <= div + 2'h1;
		end
	end

	// device drive wins, else the remote clock or the pull-up
	assign pin_i = !pin_oe_n ? pin_o : rclk;
endmodule // spc_remote

`default_nettype wire

// file: spc_ctrl_chk.sv
// Purpose: port-level checks of the serial control block
// Assumes: control and mode only change by bus writes or filter clear
// Notes: shadow registers track the control and mode values
`default_nettype none

module spc_ctrl_chk
#(
	parameter int ADDR_W = 3 // register index width
)
(
	input wire logic mclk, // system clock
	input wire logic rstn, // reset, low active
	input wire logic [ADDR_W-1:0] reg_addr, // register index
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_rdata, // read data
	input wire logic rx_char_done, // character received
	input wire logic rx_mpb, // its multiprocessor bit
	input wire logic serial_clk_pin_oe_n, // pin enable
	input wire logic rx_accept, // character stored
	input wire logic brg_internal, // internal generator
	input wire logic ext_clk_16x, // pin clock 16x
	input wire logic tx_empty_irq, // request
	input wire logic rx_full_irq, // request
	input wire logic rx_err_irq, // request
	input wire logic tx_done_irq // request
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctl;
	logic [7:0] md;
	logic live;
	logic [1:0] cs;

	// filter live and clock code
	assign live = ctl[3] && md[2] && !md[7];
	assign cs = ctl[1:0];

	// shadow of control and mode, hardware filter clear last
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ctl <= 8'h00;
			md <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == ADDR_W'(0))
				ctl <= reg_wdata;
			if (reg_wr && reg_addr == ADDR_W'(1))
				md <= reg_wdata;
			if (rx_char_done && ctl[4] && live && rx_mpb)
				ctl[3] <= 1'b0;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	property p_txe_en;
		tx_empty_irq |-> ctl[7] || $past(ctl[7]);
	endproperty
	a_txe_en: assert property (p_txe_en) else $error("txe req");
	property p_rx_en;
		(rx_full_irq || rx_err_irq) |-> ctl[6] || $past(ctl[6]);
	endproperty
	a_rx_en: assert property (p_rx_en) else $error("rx req");
	property p_txd_en;
		tx_done_irq |-> ctl[2] || $past(ctl[2]);
	endproperty
	a_txd_en: assert property (p_txd_en) else $error("txd req");
	property p_tx_off;
		(ctl[7] && !ctl[5])[*3] |=> tx_empty_irq;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("txe off");
	property p_rx_off;
		rx_char_done && !ctl[4] |=> !rx_accept;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("rx off");
	property p_drop;
		rx_char_done && live && !rx_mpb |=> !rx_accept;
	endproperty
	a_drop: assert property (p_drop) else $error("drop");
	property p_rd_ctl;
		reg_rd && reg_addr == ADDR_W'(0) |=> reg_rdata == $past(ctl);
	endproperty
	a_rd_ctl: assert property (p_rd_ctl) else $error("ctl");
	property p_rd_idle;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata");
	property p_a00;
		(!md[7] && cs == 2'h0)[*3] |-> brg_internal && serial_clk_pin_oe_n;
	endproperty
	a_a00: assert property (p_a00) else $error("a00");
	property p_out;
		((md[7] && cs == 2'h0) || (!md[7] && cs == 2'h1))[*3]
			|-> brg_internal && !serial_clk_pin_oe_n;
	endproperty
	a_out: assert property (p_out) else $error("out");
	property p_a10;
		(!md[7] && cs == 2'h2)[*3]
			|-> serial_clk_pin_oe_n && !brg_internal && ext_clk_16x;
	endproperty
	a_a10: assert property (p_a10) else $error("a10");
	property p_rsv;
		(cs == 2'h3 || (md[7] && cs != 2'h0))[*3]
			|-> serial_clk_pin_oe_n && !brg_internal && !ext_clk_16x;
	endproperty
	a_rsv: assert property (p_rsv) else $error("rsv");

	c_drop: cover property (rx_char_done && live && !rx_mpb);
	c_ext: cover property (md[7] && cs == 2'h2);
	c_irq: cover property (rx_err_irq);
endmodule // spc_ctrl_chk

bind spc_ctrl spc_ctrl_chk #(.ADDR_W(ADDR_W)) i_chk (
	.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.rx_char_done(rx_char_done), .rx_mpb(rx_mpb),
	.serial_clk_pin_oe_n(serial_clk_pin_oe_n), .rx_accept(rx_accept),
	.brg_internal(brg_internal), .ext_clk_16x(ext_clk_16x),
	.tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq),
	.rx_err_irq(rx_err_irq), .tx_done_irq(tx_done_irq));

`default_nettype wire

// file: spc_ctrl_tb.sv
// Purpose: register and pin level tests of the serial control block
// Assumes: half-bit tick every four cycles, remote clock on demand
// Notes: expected values follow the register map and reset values
`default_nettype none

module spc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, clk_run = 0;
	logic [2:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0, reg_rdata, tx_data;
	logic tx_shift_load = 0, tx_last_bit = 0, rx_char_done = 0, rx_mpb = 0;
	logic rx_frame_err = 0, rx_parity_err = 0, rx_overrun = 0;
	logic half_bit_tick = 0, pin_i, pin_o, pin_oe_n, tx_run, rx_run;
	logic rx_accept, tx_data_wr, brg_internal, ext_clk_16x, ext_clk_edge;
	logic tx_empty_irq, rx_full_irq, rx_err_irq, tx_done_irq, irq;
	logic [1:0] tick_cnt = '0;
	logic prev_o;
	int num_errors = 0, check_count = 0, tog, edg;
	logic [4:0] tbl [8] = '{5'h18, 5'h0a, 5'h15, 5'h10,
		5'h0a, 5'h10, 5'h11, 5'h10};

	spc_ctrl i_dut (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .tx_shift_load, .tx_last_bit, .rx_char_done, .rx_mpb,
		.rx_frame_err, .rx_parity_err, .rx_overrun, .half_bit_tick,
		.serial_clk_pin_i(pin_i), .serial_clk_pin_o(pin_o),
		.serial_clk_pin_oe_n(pin_oe_n), .tx_run, .rx_run, .rx_accept,
		.tx_data, .tx_data_wr, .brg_internal, .ext_clk_16x, .ext_clk_edge,
		.tx_empty_irq, .rx_full_irq, .rx_err_irq, .tx_done_irq, .irq);
	spc_remote i_remote (.mclk, .rstn, .clk_run, .pin_o, .pin_oe_n,
		.pin_i);

	// clock and half-bit tick
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		tick_cnt <= tick_cnt + 2'h1;
		half_bit_tick <= (tick_cnt == 2'h3);
	end

	task chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk8(reg_rdata, exp);
	endtask
	task rxc(input logic m, input logic [2:0] e);
		@(posedge mclk);
		rx_char_done <= 1'b1;
		rx_mpb <= m;
		{rx_frame_err, rx_parity_err, rx_overrun} <= e;
		@(posedge mclk);
		rx_char_done <= 1'b0;
		{rx_frame_err, rx_parity_err, rx_overrun} <= 3'h0;
	endtask
	task txp(input logic sh, input logic lb);
		@(posedge mclk);
		{tx_shift_load, tx_last_bit} <= {sh, lb};
		@(posedge mclk);
		{tx_shift_load, tx_last_bit} <= 2'h0;
	endtask
	task settle;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task conclude;
		$display("errors=%0d checks=%0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (5000) @(posedge mclk);
		num_errors++;
		conclude();
	end

	// main sequence
	initial begin
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		rd(0, 8'h00);
		rd(2, 8'h84);
		rd(7, 8'h00);
		wr(0, 8'ha4);
		rd(0, 8'ha4);
		wr(0, 8'h84);
		wr(4, 8'h33);
		#1 chk1(tx_data_wr, 1'b0);
		wr(2, 8'hfc);
		rd(2, 8'h84);
		settle();
		chk1(tx_empty_irq, 1'b1);
		wr(0, 8'ha0);
		wr(4, 8'h5a);
		#1 chk1(tx_data_wr, 1'b1);
		chk8(tx_data, 8'h5a);
		rd(2, 8'h00);
		settle();
		chk1(tx_empty_irq, 1'b0);
		chk1(tx_run, 1'b1);
		chk1(rx_run, 1'b0);
		txp(1'b1, 1'b0);
		settle();
		chk1(tx_empty_irq, 1'b1);
		txp(1'b0, 1'b1);
		rd(2, 8'h84);
		chk1(tx_done_irq, 1'b0);
		wr(0, 8'h24);
		settle();
		chk1(tx_empty_irq, 1'b0);
		chk1(tx_done_irq, 1'b1);
		wr(3, 8'h04);
		settle();
		chk1(irq, 1'b1);
		wr(2, 8'h04);
		settle();
		chk1(irq, 1'b0);
		wr(0, 8'h70);
		rxc(1'b0, 3'h0);
		#1 chk1(rx_accept, 1'b1);
		rd(2, 8'hc0);
		settle();
		chk1(rx_full_irq, 1'b1);
		rxc(1'b1, 3'h4);
		rd(2, 8'hd2);
		settle();
		chk1(rx_err_irq, 1'b1);
		wr(0, 8'h30);
		settle();
		chk1(rx_full_irq | rx_err_irq, 1'b0);
		wr(2, 8'h78);
		wr(0, 8'h60);
		rxc(1'b0, 3'h0);
		#1 chk1(rx_accept, 1'b0);
		rd(2, 8'h82);
		wr(1, 8'h04);
		wr(0, 8'h78);
		rxc(1'b0, 3'h5);
		#1 chk1(rx_accept, 1'b0);
		rd(2, 8'h82);
		rd(0, 8'h78);
		rxc(1'b1, 3'h0);
		#1 chk1(rx_accept, 1'b1);
		rd(0, 8'h70);
		rd(2, 8'hc2);
		wr(2, 8'h40);
		wr(1, 8'h84);
		rd(1, 8'h84);
		wr(0, 8'h78);
		rxc(1'b0, 3'h0);
		rd(2, 8'hc0);
		rd(0, 8'h78);
		clk_run <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			wr(1, {i[2], 7'h00});
			wr(0, {6'h00, i[1:0]});
			repeat (4) @(posedge mclk);
			tog = 0;
			edg = 0;
			#1 prev_o = pin_o;
			for (int k = 0; k < 32; k++) begin
				@(posedge mclk);
				#1;
				edg += int'(ext_clk_edge);
				tog += int'(pin_o !== prev_o);
				prev_o = pin_o;
			end
			chk1(pin_oe_n, tbl[i][4]);
			chk1(brg_internal, tbl[i][3]);
			chk1(ext_clk_16x, tbl[i][2]);
			chk1(tog != 0, tbl[i][1]);
			chk1(edg != 0, tbl[i][0]);
		end
		conclude();
	end
endmodule // spc_ctrl_tb

`default_nettype wire
